// File: rtl/pbs_map.svh
`ifndef PBS_MAP_SVH
`define PBS_MAP_SVH

// register lengths
`define PBS_IR_LEN 3
`define PBS_ID_LEN 32
`define PBS_BSR_LEN 361

// instruction codes
`define PBS_OP_EXTEST 3'h0
`define PBS_OP_IDCODE 3'h1
`define PBS_OP_SAMPLE 3'h2
`define PBS_OP_CLAMP 3'h3
`define PBS_OP_HIGHZ 3'h4
`define PBS_OP_BYPASS 3'h7

// fixed instruction capture value
`define PBS_IR_CAPTURE 3'h1

// identification code layout
`define PBS_ID_MARK 1'h1
`define PBS_ID_MFR_W 11
`define PBS_ID_PART_W 16
`define PBS_ID_VER_W 4

// boundary cell layout: three cells per pin, one global enable cell
`define PBS_NUM_IO 120
`define PBS_CELLS_PER_IO 3
`define PBS_CELL_IN 0
`define PBS_CELL_OUT 1
`define PBS_CELL_OE 2
`define PBS_CELL_GLOBAL 360

`endif

// File: rtl/pbs_pkg.sv
`include "pbs_map.svh"

package pbs_pkg;

  // tap states, gray along the usual path
  typedef enum logic [3:0] {
    PBS_ST_TLR      = 4'h0,
    PBS_ST_RTI      = 4'h1,
    PBS_ST_SEL_DR   = 4'h3,
    PBS_ST_CAP_DR   = 4'h2,
    PBS_ST_SHIFT_DR = 4'h6,
    PBS_ST_EX1_DR   = 4'h7,
    PBS_ST_PAUSE_DR = 4'h5,
    PBS_ST_EX2_DR   = 4'h4,
    PBS_ST_UPD_DR   = 4'hC,
    PBS_ST_SEL_IR   = 4'hD,
    PBS_ST_CAP_IR   = 4'hF,
    PBS_ST_SHIFT_IR = 4'hE,
    PBS_ST_EX1_IR   = 4'hA,
    PBS_ST_PAUSE_IR = 4'hB,
    PBS_ST_EX2_IR   = 4'h9,
    PBS_ST_UPD_IR   = 4'h8
  } pbs_state_type;

  typedef enum logic [`PBS_IR_LEN-1:0] {
    PBS_EXTEST = `PBS_OP_EXTEST,
    PBS_IDCODE = `PBS_OP_IDCODE,
    PBS_SAMPLE = `PBS_OP_SAMPLE,
    PBS_CLAMP  = `PBS_OP_CLAMP,
    PBS_HIGHZ  = `PBS_OP_HIGHZ,
    PBS_BYPASS = `PBS_OP_BYPASS
  } pbs_instr_type;

  typedef logic [`PBS_NUM_IO-1:0] pbs_pins_type;
  typedef logic [`PBS_BSR_LEN-1:0] pbs_bsr_type;

  // test clock, rising edge
  typedef struct packed {
    pbs_state_type state;
    logic [`PBS_IR_LEN-1:0] irShift;
    logic bypass;
    logic [`PBS_ID_LEN-1:0] idShift;
    pbs_bsr_type bsrShift;
    logic snapReqTgl;
  } pbs_rise_type;

  // test clock, falling edge
  typedef struct packed {
    pbs_instr_type irCur;
    pbs_bsr_type bsrUpd;
    logic [`PBS_ID_LEN-1:0] idUpd;
    logic updTgl;
    logic inReset;
    logic tdo;
    logic tdoOe;
  } pbs_fall_type;

  // system clock
  typedef struct packed {
    logic updS1;
    logic updS2;
    logic updS3;
    logic rstS1;
    logic rstS2;
    logic reqS1;
    logic reqS2;
    logic reqS3;
    pbs_instr_type mode;
    pbs_bsr_type bsrCopy;
    pbs_bsr_type snap;
    pbs_pins_type padInS1;
    pbs_pins_type padInS2;
    pbs_pins_type padOut;
    pbs_pins_type padOe;
  } pbs_sys_type;

  localparam pbs_rise_type PBS_RISE_RST = '{state: PBS_ST_TLR, default: '0};
  localparam pbs_fall_type PBS_FALL_RST = '{irCur: PBS_IDCODE, inReset: 1'h1,
                                            default: '0};
  localparam pbs_sys_type PBS_SYS_RST = '{rstS1: 1'h1, rstS2: 1'h1,
                                          mode: PBS_IDCODE, default: '0};

endpackage

// File: rtl/pbs_tap.sv
`timescale 1ns/1ps
`include "pbs_map.svh"

//
// Function
// - state moves only on test clock rise, or to reset state when test reset goes low
// - power-up: reset state, IDCODE, ID selected
// - select-DR: capture-DR low, select-IR high
// - capture-DR loads selected register if allowed
// - shift-DR shifts selected register toward output
// - exit1-DR: update-DR high, pause-DR low
// - pause-DR holds, exit2-DR on high
// - exit2-DR: update-DR high, shift-DR low
// - update-DR falling edge latches parallel outputs
// - select-IR: capture-IR low, reset high
// - capture-IR loads fixed instruction value
// - shift-IR shifts instruction, others hold
// - exit1-IR/pause-IR transitions, pause holds
// - exit2-IR: update-IR high, shift-IR low
// - update-IR falling edge makes instruction current
// - lengths: IR 3, ID 32, boundary 361
// - 010 sample, 000 extest, 001 idcode
// - 111, 011, 100 select bypass
// - sample captures pins, shift preloads
// - extest drives outputs from boundary latch
// - idcode captures one-marked identification code
// - highz floats outputs; clamp holds boundary values
module pbs_tap #(
  // identification fields, values arbitrary
  parameter logic [`PBS_ID_VER_W-1:0] ID_VERSION = 4'h1,
  parameter logic [`PBS_ID_PART_W-1:0] ID_PART = 16'h0001,
  parameter logic [`PBS_ID_MFR_W-1:0] ID_MFR = 11'h001
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic periph_test_clock,
  input wire logic periph_test_reset_n,
  input wire logic periph_test_mode_select,
  input wire logic periph_test_data_in,
  output logic periph_test_data_out,
  output logic periph_test_data_out_oe,
  input wire pbs_pkg::pbs_pins_type coreOut,
  input wire pbs_pkg::pbs_pins_type coreOe,
  input wire pbs_pkg::pbs_pins_type padIn,
  output pbs_pkg::pbs_pins_type padOut,
  output pbs_pkg::pbs_pins_type padOe,
  output logic [`PBS_ID_LEN-1:0] idLatched
);
  import pbs_pkg::*;

  localparam logic [`PBS_ID_LEN-1:0] ID_CODE =
    {ID_VERSION, ID_PART, ID_MFR, `PBS_ID_MARK};

  pbs_rise_type rise_r;
  pbs_rise_type rise_nxt;
  pbs_fall_type fall_r;
  pbs_fall_type fall_nxt;
  pbs_sys_type sys_r;
  pbs_sys_type sys_nxt;

  logic selBsr;
  logic selId;
  logic tms;

  assign tms = periph_test_mode_select;

  // ---------------------------------------------------------------
  // register selection by current instruction
  // ---------------------------------------------------------------
  always_comb begin
    selBsr = 1'h0;
    selId = 1'h0;
    unique case (fall_r.irCur)
      PBS_SAMPLE, PBS_EXTEST: selBsr = 1'h1;
      PBS_IDCODE: selId = 1'h1;
      default: begin
        // bypass, clamp, highz and unused codes
        selBsr = 1'h0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // tap controller and shift paths, rising edge
  // ---------------------------------------------------------------
  always_comb begin
    rise_nxt = rise_r;
    unique case (rise_r.state)
      PBS_ST_TLR: begin
        rise_nxt.state = tms ? PBS_ST_TLR : PBS_ST_RTI;
      end
      PBS_ST_RTI: begin
        rise_nxt.state = tms ? PBS_ST_SEL_DR : PBS_ST_RTI;
      end
      PBS_ST_SEL_DR: begin
        rise_nxt.state = tms ? PBS_ST_SEL_IR : PBS_ST_CAP_DR;
      end
      PBS_ST_CAP_DR: begin
        if (selBsr) begin
          rise_nxt.bsrShift = sys_r.snap;
        end else if (selId) begin
          rise_nxt.idShift = ID_CODE;
        end else begin
          rise_nxt.bypass = 1'h0;
        end
        rise_nxt.state = tms ? PBS_ST_EX1_DR : PBS_ST_SHIFT_DR;
      end
      PBS_ST_SHIFT_DR: begin
        if (selBsr) begin
          rise_nxt.bsrShift = {periph_test_data_in,
                               rise_r.bsrShift[`PBS_BSR_LEN-1:1]};
        end else if (selId) begin
          rise_nxt.idShift = {periph_test_data_in,
                              rise_r.idShift[`PBS_ID_LEN-1:1]};
        end else begin
          rise_nxt.bypass = periph_test_data_in;
        end
        rise_nxt.state = tms ? PBS_ST_EX1_DR : PBS_ST_SHIFT_DR;
      end
      PBS_ST_EX1_DR: begin
        rise_nxt.state = tms ? PBS_ST_UPD_DR : PBS_ST_PAUSE_DR;
      end
      PBS_ST_PAUSE_DR: begin
        rise_nxt.state = tms ? PBS_ST_EX2_DR : PBS_ST_PAUSE_DR;
      end
      PBS_ST_EX2_DR: begin
        rise_nxt.state = tms ? PBS_ST_UPD_DR : PBS_ST_SHIFT_DR;
      end
      PBS_ST_UPD_DR: begin
        rise_nxt.state = tms ? PBS_ST_SEL_DR : PBS_ST_RTI;
      end
      PBS_ST_SEL_IR: begin
        rise_nxt.state = tms ? PBS_ST_TLR : PBS_ST_CAP_IR;
      end
      PBS_ST_CAP_IR: begin
        rise_nxt.irShift = `PBS_IR_CAPTURE;
        rise_nxt.state = tms ? PBS_ST_EX1_IR : PBS_ST_SHIFT_IR;
      end
      PBS_ST_SHIFT_IR: begin
        rise_nxt.irShift = {periph_test_data_in,
                            rise_r.irShift[`PBS_IR_LEN-1:1]};
        rise_nxt.state = tms ? PBS_ST_EX1_IR : PBS_ST_SHIFT_IR;
      end
      PBS_ST_EX1_IR: begin
        rise_nxt.state = tms ? PBS_ST_UPD_IR : PBS_ST_PAUSE_IR;
      end
      PBS_ST_PAUSE_IR: begin
        rise_nxt.state = tms ? PBS_ST_EX2_IR : PBS_ST_PAUSE_IR;
      end
      PBS_ST_EX2_IR: begin
        rise_nxt.state = tms ? PBS_ST_UPD_IR : PBS_ST_SHIFT_IR;
      end
      PBS_ST_UPD_IR: begin
        rise_nxt.state = tms ? PBS_ST_SEL_DR : PBS_ST_RTI;
      end
    endcase
    // ask system side for a pin snapshot two edges before capture
    if (rise_nxt.state == PBS_ST_SEL_DR &&
        rise_r.state != PBS_ST_SEL_DR) begin
      rise_nxt.snapReqTgl = ~rise_r.snapReqTgl;
    end
  end

  always_ff @(posedge periph_test_clock or negedge periph_test_reset_n) begin
    if (!periph_test_reset_n) begin
      rise_r <= PBS_RISE_RST;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  // ---------------------------------------------------------------
  // update latches and serial output, falling edge
  // ---------------------------------------------------------------
  always_comb begin
    fall_nxt = fall_r;
    fall_nxt.tdoOe = 1'h0;
    fall_nxt.inReset = 1'h0;
    unique case (rise_r.state)
      PBS_ST_TLR: begin
        fall_nxt.irCur = PBS_IDCODE;
        fall_nxt.inReset = 1'h1;
      end
      PBS_ST_UPD_IR: begin
        fall_nxt.irCur = pbs_instr_type'(rise_r.irShift);
        fall_nxt.updTgl = ~fall_r.updTgl;
      end
      PBS_ST_UPD_DR: begin
        if (selBsr) begin
          fall_nxt.bsrUpd = rise_r.bsrShift;
        end
        if (selId) begin
          fall_nxt.idUpd = rise_r.idShift;
        end
        fall_nxt.updTgl = ~fall_r.updTgl;
      end
      PBS_ST_SHIFT_IR: begin
        fall_nxt.tdo = rise_r.irShift[0];
        fall_nxt.tdoOe = 1'h1;
      end
      PBS_ST_SHIFT_DR: begin
        if (selBsr) begin
          fall_nxt.tdo = rise_r.bsrShift[0];
        end else if (selId) begin
          fall_nxt.tdo = rise_r.idShift[0];
        end else begin
          fall_nxt.tdo = rise_r.bypass;
        end
        fall_nxt.tdoOe = 1'h1;
      end
      default: begin
        // remaining states leave latches alone
        fall_nxt.inReset = 1'h0;
      end
    endcase
  end

  always_ff @(negedge periph_test_clock or negedge periph_test_reset_n) begin
    if (!periph_test_reset_n) begin
      fall_r <= PBS_FALL_RST;
    end else begin
      fall_r <= fall_nxt;
    end
  end

  // ---------------------------------------------------------------
  // system side: crossings, pin snapshot, output muxing
  // ---------------------------------------------------------------
  always_comb begin
    sys_nxt = sys_r;
    sys_nxt.updS1 = fall_r.updTgl;
    sys_nxt.updS2 = sys_r.updS1;
    sys_nxt.updS3 = sys_r.updS2;
    sys_nxt.rstS1 = fall_r.inReset;
    sys_nxt.rstS2 = sys_r.rstS1;
    sys_nxt.reqS1 = rise_r.snapReqTgl;
    sys_nxt.reqS2 = sys_r.reqS1;
    sys_nxt.reqS3 = sys_r.reqS2;
    sys_nxt.padInS1 = padIn;
    sys_nxt.padInS2 = sys_r.padInS1;

    // latched values are stable long before the toggle arrives
    if (sys_r.rstS2) begin
      sys_nxt.mode = PBS_IDCODE;
    end else if (sys_r.updS2 != sys_r.updS3) begin
      sys_nxt.mode = fall_r.irCur;
      sys_nxt.bsrCopy = fall_r.bsrUpd;
    end

    // snapshot held until the next request, read at capture
    if (sys_r.reqS2 != sys_r.reqS3) begin
      for (int k = 0; k < `PBS_NUM_IO; k++) begin
        sys_nxt.snap[k*`PBS_CELLS_PER_IO + `PBS_CELL_IN] =
          sys_r.padInS2[k];
        sys_nxt.snap[k*`PBS_CELLS_PER_IO + `PBS_CELL_OUT] =
          coreOut[k];
        sys_nxt.snap[k*`PBS_CELLS_PER_IO + `PBS_CELL_OE] =
          coreOe[k];
      end
      sys_nxt.snap[`PBS_CELL_GLOBAL] = 1'h1;
    end

    for (int k = 0; k < `PBS_NUM_IO; k++) begin
      unique case (sys_r.mode)
        PBS_EXTEST, PBS_CLAMP: begin
          sys_nxt.padOut[k] =
            sys_r.bsrCopy[k*`PBS_CELLS_PER_IO + `PBS_CELL_OUT];
          sys_nxt.padOe[k] =
            sys_r.bsrCopy[k*`PBS_CELLS_PER_IO + `PBS_CELL_OE] &
            sys_r.bsrCopy[`PBS_CELL_GLOBAL];
        end
        PBS_HIGHZ: begin
          sys_nxt.padOut[k] = coreOut[k];
          sys_nxt.padOe[k] = 1'h0;
        end
        default: begin
          // normal function under sample, bypass and idcode
          sys_nxt.padOut[k] = coreOut[k];
          sys_nxt.padOe[k] = coreOe[k];
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_r <= PBS_SYS_RST;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign periph_test_data_out = fall_r.tdo;
  assign periph_test_data_out_oe = fall_r.tdoOe;
  assign padOut = sys_r.padOut;
  assign padOe = sys_r.padOe;
  assign idLatched = fall_r.idUpd;

endmodule

// File: tb/pbs_tap_properties.sv
`timescale 1ns/1ps
`include "pbs_map.svh"
// ----------------------------------------
// port checks for the test access port
// ----------------------------------------
module pbs_tap_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic periph_test_clock,
  input wire logic periph_test_reset_n,
  input wire logic periph_test_mode_select,
  input wire logic periph_test_data_in,
  input wire logic periph_test_data_out,
  input wire logic periph_test_data_out_oe,
  input wire pbs_pkg::pbs_pins_type coreOut,
  input wire pbs_pkg::pbs_pins_type coreOe,
  input wire pbs_pkg::pbs_pins_type padIn,
  input wire pbs_pkg::pbs_pins_type padOut,
  input wire pbs_pkg::pbs_pins_type padOe,
  input wire logic [`PBS_ID_LEN-1:0] idLatched
);
  import pbs_pkg::*;
  sequence five_highs;
    periph_test_mode_select [*5];
  endsequence
  sequence tap_held;
    (rst_n && !periph_test_reset_n) [*6];
  endsequence
  chk_tms_reset: assert property (@(posedge periph_test_clock)
    disable iff (!periph_test_reset_n) five_highs |=>
    !periph_test_data_out_oe) else $error("five highs kept shift");
  chk_oe_async: assert property (@(posedge clk_sys)
    disable iff (!rst_n) !periph_test_reset_n |->
    !periph_test_data_out_oe) else $error("oe high in test reset");
  chk_oe_enter: assert property (@(posedge periph_test_clock)
    disable iff (!periph_test_reset_n) $rose(periph_test_data_out_oe)
    |-> !$past(periph_test_mode_select)) else $error("bad shift entry");
  chk_oe_leave: assert property (@(posedge periph_test_clock)
    disable iff (!periph_test_reset_n) $fell(periph_test_data_out_oe)
    |-> $past(periph_test_mode_select)) else $error("bad shift exit");
  chk_shift_hold: assert property (@(posedge periph_test_clock)
    disable iff (!periph_test_reset_n) periph_test_data_out_oe &&
    !periph_test_mode_select |=> periph_test_data_out_oe)
    else $error("shift left with select low");
  chk_tdo_fall: assert property (@(posedge clk_sys)
    disable iff (!rst_n || !periph_test_reset_n)
    $changed(periph_test_data_out) |-> !periph_test_clock)
    else $error("data out moved off falling edge");
  chk_id_update: assert property (@(posedge periph_test_clock)
    disable iff (!periph_test_reset_n) $changed(idLatched) |->
    $past(periph_test_mode_select)) else $error("id latch moved");
  chk_pads_core: assert property (@(posedge clk_sys)
    disable iff (!rst_n) tap_held |-> padOut == $past(coreOut) &&
    padOe == $past(coreOe)) else $error("pads not normal in reset");
endmodule

bind pbs_tap pbs_tap_properties u_props (.clk_sys, .rst_n,
  .periph_test_clock, .periph_test_reset_n, .periph_test_mode_select,
  .periph_test_data_in, .periph_test_data_out, .periph_test_data_out_oe,
  .coreOut, .coreOe, .padIn, .padOut, .padOe, .idLatched);

// File: tb/pbs_tester.sv
`timescale 1ns/1ps
// ----------------------------------------
// boundary-scan tester on the far side
// ----------------------------------------
module pbs_tester (
  output logic tck,
  output logic trstN,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdoOe
);
  logic [429:0] junk;
  initial begin
    tck = 1'b0;
    trstN = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // clock stands low between frames; pin read before each rise
  task automatic run(input int n, input logic [429:0] tmsV,
                     input logic [429:0] tdiV, output logic [429:0] outV);
    outV = '0;
    #0.7;
    for (int i = 0; i < n; i++) begin
      tms = tmsV[i];
      tdi = tdiV[i];
      #16;
      outV[i] = tdoOe ? tdo : 1'bz;
      tck = 1'b1;
      #16;
      tck = 1'b0;
    end
    tdi = ~tdi;
  endtask
  task automatic pulse_reset();
    trstN = 1'b0;
    run(2, '1, '0, junk);
    trstN = 1'b1;
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "pbs_map.svh"
`define CHK(nm, e, s) begin samplesChecked++; if ((s) !== (e)) begin \
  errorCnt++; $display("[ERR] %s exp %0h seen %0h", nm, e, s); end end
// ----------------------------------------
// self-checking bench for the test access port
// ----------------------------------------
module testbench;
  import pbs_pkg::*;
  // identification fields, values arbitrary
  localparam logic [31:0] IDC = {4'h5, 16'hC3A9, 11'h2B5, 1'h1};
  typedef struct packed {
    logic [2:0] code;
    logic [8:0] len;
    logic normal;
  } pbs_row_type;
  pbs_row_type rows [8] = '{
    '{`PBS_OP_SAMPLE, 9'h169, 1'h1}, '{`PBS_OP_EXTEST, 9'h169, 1'h0},
    '{`PBS_OP_CLAMP, 9'h001, 1'h0}, '{`PBS_OP_HIGHZ, 9'h001, 1'h0},
    '{`PBS_OP_BYPASS, 9'h001, 1'h1}, '{3'h5, 9'h001, 1'h1},
    '{3'h6, 9'h001, 1'h1}, '{`PBS_OP_IDCODE, 9'h020, 1'h1}};
  logic clkSys, rstN, tck, trstN, tms, tdi, tdo, tdoOe;
  pbs_pins_type coreOut, coreOe, padIn, padOut, padOe;
  logic [429:0] dout;
  logic [31:0] idLat;
  int errorCnt = 0;
  int samplesChecked = 0;
  pbs_tester tester (.tck, .trstN, .tms, .tdi, .tdo, .tdoOe);
  pbs_tap #(.ID_VERSION(IDC[31:28]), .ID_PART(IDC[27:12]),
    .ID_MFR(IDC[11:1])) DUT (.clk_sys(clkSys), .rst_n(rstN),
    .periph_test_clock(tck), .periph_test_reset_n(trstN),
    .periph_test_mode_select(tms), .periph_test_data_in(tdi),
    .periph_test_data_out(tdo), .periph_test_data_out_oe(tdoOe),
    .coreOut, .coreOe, .padIn, .padOut, .padOe, .idLatched(idLat));
  task automatic ir_load(input logic [2:0] c);
    tester.run(9, 430'h0C3, {423'h0, c, 4'h0}, dout);
  endtask
  // 425 clocks with select held low, marker byte at data bits 3 to 10, zeros behind it
  task automatic dr_scan();
    tester.run(425, 430'h0, {419'h0, 8'hA5, 3'h0}, dout);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clkSys = 1'b0;
    forever #2 clkSys = ~clkSys;
  end
  initial begin
    #400000;
    errorCnt++;
    close_out();
  end
  initial begin
    rstN = 1'b0;
    coreOut = {30{4'h9}};
    coreOe = '1;
    padIn = '1;
    repeat (6) @(posedge clkSys);
    #1;
    rstN = 1'b1;
    tester.pulse_reset();
    // one low edge walks from reset state to idle
    tester.run(1, '0, '0, dout);
    tester.run(425, {6'h0, 1'h1, 1'h1, 421'h0, 1'h1}, {419'h0, 8'hA5, 3'h0},
               dout);
    `CHK("power-up id", IDC, dout[34:3])
    `CHK("id latch", 32'h0, idLat)
    $display("power-up test done");
    foreach (rows[i]) begin
      ir_load(rows[i].code);
      `CHK("ir capture", 3'h1, dout[6:4])
      tester.run(425, {6'h0, 1'h1, 1'h1, 421'h0, 1'h1},
                 {419'h0, 8'hA5, 3'h0}, dout);
      `CHK("path", 8'hA5, dout[3+rows[i].len+:8])
      if (rows[i].len == 9'h020)
        `CHK("id code", IDC, dout[34:3])
      else if (rows[i].len == 9'h001)
        `CHK("bypass capture", 1'h0, dout[3])
      else
        `CHK("pin capture", padIn[0], dout[3])
      repeat (8) @(posedge clkSys);
      #1;
      `CHK("pad oe", rows[i].normal ? coreOe : '0, padOe)
      if (rows[i].code != `PBS_OP_HIGHZ)
        `CHK("pad out", rows[i].normal ? coreOut : '0, padOut)
      $display("row %0d code %0h done", i, rows[i].code);
    end
    tester.run(13, 430'hD23, 430'h430, dout);
    tester.run(425, {6'h0, 1'h1, 1'h1, 421'h0, 1'h1}, {419'h0, 8'hA5, 3'h0},
               dout);
    `CHK("paused ir load", 8'hA5, dout[11:4])
    $display("pause test done");
    tester.run(7, 430'h3F, '0, dout);
    tester.run(425, {6'h0, 1'h1, 1'h1, 421'h0, 1'h1}, {419'h0, 8'hA5, 3'h0},
               dout);
    `CHK("tms reset id", IDC, dout[34:3])
    $display("tms reset test done");
    close_out();
  end
endmodule
